//--- verilog/burst_sram_params.svh
// Function
// - Register all synchronous inputs on rising clock
// - Two-bit burst counter after loaded address
// - Static input picks interleaved or linear order
// - Low selects linear, high selects interleaved
// - Data drivers enabled by output enable, forced off during sleep request
// - Writes update one to four selected lanes
// - Either strobe starts burst; step advances it
// - Each lane strobe gates its byte and parity
// - Lane strobes need gate low, same cycle
// - All-lanes write writes every lane
// - Parity storage only on 18/36-bit variants
// - Registered writes complete self-timed
// - Controller strobe aborts burst, loads address
// - Controller strobe, primary deselect: power-down
// - Processor strobe starts read, needs selects
// - Processor strobe ignored if primary high
// - Processor strobe with bad selects: power-down
// - Step low advances, high holds (wait)
// - Sleep request: standby, keep data, ignore inputs
`ifndef BURST_SRAM_PARAMS_SVH
`define BURST_SRAM_PARAMS_SVH
`define ADDR_W        10
`define LANES         4
`define BYTE_W        8
`define HAS_PARITY    1
`define LANE_W        (`BYTE_W + `HAS_PARITY)
`define WORD_W        (`LANES * `LANE_W)
`define DEPTH         (1 << `ADDR_W)
`define CNT_ZERO      2'h0
`define CNT_ONE       2'h1
`define OFFS_W        2
`endif

//--- verilog/burst_sram_pkg.sv
`include "burst_sram_params.svh"
package burst_sram_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} op_t;
    typedef struct packed {
        logic                  ctl_strobe_n;
        logic                  proc_strobe_n;
        logic                  burst_step_n;
        logic                  primary_select_n;
        logic                  secondary_select_n;
        logic                  high_select;
        logic                  lane_write_gate_n;
        logic                  all_lanes_write_n;
        logic [`LANES-1:0]     lane_write_n;
    } ctrl_t;
endpackage

//--- verilog/burst_sram_port.sv
`timescale 1ns/10ps
`include "burst_sram_params.svh"
module burst_sram_port
    import burst_sram_pkg::*;
(
    // Clock and reset
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST,
    // Static and asynchronous controls
    input  wire logic                 SEQUENCE_SELECT,
    input  wire logic                 OUTPUT_ENABLE_N,
    input  wire logic                 SLEEP_REQUEST,
    // Synchronous bus
    input  wire logic [`ADDR_W-1:0]   ADDR,
    input  wire ctrl_t                CTRL,
    // Data lanes, parity in the top bit of each lane
    input  wire logic [`WORD_W-1:0]   DATA_IN,
    output logic      [`WORD_W-1:0]   DATA_OUT,
    output logic      [`WORD_W-1:0]   DATA_OE,
    // Status
    output logic                      POWER_DOWN
);

    logic [`LANE_W-1:0]   rd_lane [`LANES];
    logic [`ADDR_W-1:0]   base_ff;
    logic [1:0]           cnt_ff;
    logic [`ADDR_W-1:0]   addr_ff;
    logic [`WORD_W-1:0]   din_ff;
    logic [`LANES-1:0]    wen_ff;
    op_t                  op_ff;
    logic                 pdown_ff;
    logic [`WORD_W-1:0]   dout_ff;
    logic                 act_ff;
    logic                 wr_req;
    logic                 proc_start;
    logic                 ctl_start;
    logic                 load;
    logic                 ctl_go;
    logic                 ctl_desel;
    logic                 proc_ok;
    logic [1:0]           nxt_cnt;
    logic [`LANES-1:0]    lane_en;
    logic [`ADDR_W-1:0]   cur_addr;

    // Burst offset from start bits and count
    function automatic logic [1:0] burst_offs(input logic [1:0] start,
                                              input logic [1:0] cnt,
                                              input logic       interleave);
        if (interleave)
            burst_offs = start ^ cnt;
        else
            burst_offs = start + cnt;
    endfunction

    // Lane write decode; all-lanes write overrides the gated strobes
    function automatic logic [`LANES-1:0] lanes_of(input ctrl_t c);
        if (!c.all_lanes_write_n)
            lanes_of = {`LANES{1'b1}};
        else if (!c.lane_write_gate_n)
            lanes_of = ~c.lane_write_n;
        else
            lanes_of = '0;
    endfunction

    // Processor strobe with primary select low wins over controller strobe and is a read only
    assign proc_start = !CTRL.proc_strobe_n && !CTRL.primary_select_n;
    assign proc_ok    = CTRL.high_select && !CTRL.secondary_select_n;
    assign ctl_start  = !proc_start && !CTRL.ctl_strobe_n;
    assign load       = proc_start || ctl_start;
    assign ctl_go     = ctl_start && !CTRL.primary_select_n;
    assign ctl_desel  = ctl_start && CTRL.primary_select_n;
    assign lane_en    = lanes_of(CTRL);
    assign wr_req     = |lane_en;
    assign nxt_cnt    = CTRL.burst_step_n ? cnt_ff : cnt_ff + `CNT_ONE;
    assign cur_addr   = {base_ff[`ADDR_W-1:`OFFS_W],
                         burst_offs(base_ff[`OFFS_W-1:0], nxt_cnt, SEQUENCE_SELECT)};

    // Burst address state; sleep freezes everything
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            base_ff <= '0;
            cnt_ff  <= `CNT_ZERO;
        end
        else if (!SLEEP_REQUEST)
        begin
            if (load)
            begin
                base_ff <= ADDR;
                cnt_ff  <= `CNT_ZERO;
            end
            else if (act_ff)
                cnt_ff <= nxt_cnt;
        end
    end

    // Write data captured every cycle outside sleep; only a write op uses it
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            din_ff <= '0;
        else if (!SLEEP_REQUEST)
            din_ff <= DATA_IN;
    end

    // Deselect state; selects only sampled on address load
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            pdown_ff <= 1'b1;
        else if (!SLEEP_REQUEST)
        begin
            if (proc_start)
                pdown_ff <= !proc_ok;
            else if (ctl_start)
                pdown_ff <= ctl_desel;
        end
    end

    // Burst active flag; a deselecting load ends the burst
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            act_ff <= 1'b0;
        else if (!SLEEP_REQUEST)
        begin
            if (proc_start)
                act_ff <= proc_ok;
            else if (ctl_start)
                act_ff <= ctl_go;
        end
    end

    // Operation type; continuation cycles take direction from write controls
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            op_ff <= ST_IDLE;
        else if (!SLEEP_REQUEST)
        begin
            if (proc_start)
                op_ff <= proc_ok ? ST_READ : ST_IDLE;
            else if (ctl_desel)
                op_ff <= ST_IDLE;
            else if (ctl_go || act_ff)
                op_ff <= wr_req ? ST_WRITE : ST_READ;
            else
                op_ff <= ST_IDLE;
        end
    end

    // Lane enables; a processor strobe is always a read
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            wen_ff <= '0;
        else if (!SLEEP_REQUEST)
        begin
            if (proc_start || ctl_desel)
                wen_ff <= '0;
            else if (ctl_go || act_ff)
                wen_ff <= lane_en;
            else
                wen_ff <= '0;
        end
    end

    // Array address: external on load, counter offset during a burst
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            addr_ff <= '0;
        else if (!SLEEP_REQUEST)
        begin
            if (load)
                addr_ff <= ADDR;
            else if (act_ff)
                addr_ff <= cur_addr;
        end
    end

    // One array per lane, so every array has a single writing process
    generate
        for (genvar g = 0; g < `LANES; g++)
        begin : g_lane
            logic [`LANE_W-1:0] lane_mem [0:`DEPTH-1];

            // Self-timed write from registered address and data
            always_ff @(posedge CLK_SYS)
            begin
                if (!SLEEP_REQUEST && op_ff == ST_WRITE && wen_ff[g])
                    lane_mem[addr_ff] <= din_ff[g*`LANE_W +: `LANE_W];
            end

            assign rd_lane[g] = lane_mem[addr_ff];
        end
    endgenerate

    // Read data registered one cycle after address registration
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
            dout_ff <= '0;
        else if (!SLEEP_REQUEST && op_ff == ST_READ)
        begin
            for (int i = 0; i < `LANES; i++)
                dout_ff[i*`LANE_W +: `LANE_W] <= rd_lane[i];
        end
    end

    assign DATA_OUT   = dout_ff;
    // Drive enable is combinational on purpose: the output enable is asynchronous
    assign DATA_OE    = {`WORD_W{!OUTPUT_ENABLE_N && !SLEEP_REQUEST}};
    assign POWER_DOWN = pdown_ff || SLEEP_REQUEST;

endmodule

//--- testbench/sram_monitor.sv
`timescale 1ns/10ps
`include "burst_sram_params.svh"
module sram_monitor
    import burst_sram_pkg::*;
(
    // Watched ports
    input wire logic               CLK_SYS,
    input wire logic               RST,
    input wire logic               OUTPUT_ENABLE_N,
    input wire logic               SLEEP_REQUEST,
    input wire ctrl_t              CTRL,
    input wire logic [`WORD_W-1:0] DATA_OUT,
    input wire logic [`WORD_W-1:0] DATA_OE,
    input wire logic               POWER_DOWN
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    wire go = !SLEEP_REQUEST && !CTRL.primary_select_n;
    wire ok = CTRL.high_select && !CTRL.secondary_select_n;
    wire pr = !CTRL.proc_strobe_n && go;
    wire cs = !CTRL.ctl_strobe_n && CTRL.proc_strobe_n && !SLEEP_REQUEST;
    chk_oe_gate: assert property (DATA_OE == {`WORD_W{!OUTPUT_ENABLE_N && !SLEEP_REQUEST}})
        else $error("drive enable wrong");
    chk_sleep_down: assert property (SLEEP_REQUEST |-> POWER_DOWN)
        else $error("sleep without power down");
    chk_sleep_hold: assert property ($past(SLEEP_REQUEST) && !$past(RST) |-> $stable(DATA_OUT))
        else $error("read data moved in sleep");
    chk_ctl_down: assert property (cs && CTRL.primary_select_n |=> POWER_DOWN)
        else $error("controller deselect missed");
    chk_ctl_up: assert property (cs && go |=> !POWER_DOWN || SLEEP_REQUEST)
        else $error("controller access not taken");
    chk_proc_up: assert property (pr && ok |=> !POWER_DOWN || SLEEP_REQUEST)
        else $error("processor read not taken");
    chk_proc_down: assert property (pr && !ok |=> POWER_DOWN)
        else $error("processor deselect missed");
    chk_proc_skip: assert property (!CTRL.proc_strobe_n && CTRL.primary_select_n
        && CTRL.ctl_strobe_n && !SLEEP_REQUEST ##1 !SLEEP_REQUEST |-> $stable(POWER_DOWN))
        else $error("ignored strobe changed state");
endmodule
bind burst_sram_port sram_monitor sram_monitor_i (.*);

//--- testbench/host_model.sv
`timescale 1ns/10ps
`include "burst_sram_params.svh"
module host_model
    import burst_sram_pkg::*;
(
    // Clock and read data
    input  wire logic               clk_sys,
    input  wire logic [`WORD_W-1:0] data_out,
    // Bus to the port
    output logic      [`ADDR_W-1:0] addr,
    output ctrl_t                   ctrl,
    output logic      [`WORD_W-1:0] data_in
);
    logic [`WORD_W-1:0] q [4];
    task automatic idle();
        ctrl = 12'hFFF; // Strobes off, step held, no writes
        data_in = ~data_in; // Released data is the inverse of the last word driven
    endtask
    initial
    begin
        addr = '0;
        data_in = '0;
        idle();
    end
    task automatic put(input logic [`ADDR_W-1:0] a, input ctrl_t c, input logic [`WORD_W-1:0] d);
        @(negedge clk_sys);
        addr = a;
        ctrl = c;
        data_in = d;
        @(negedge clk_sys);
        idle();
    endtask
    task automatic burst(input int n);
        // Held first edge repeats the start word, so one sample is skipped
        for (int j = 0; j <= n; j++)
        begin
            @(negedge clk_sys);
            if (j == 0)
                q[0] = data_out;
            else if (j >= 2)
                q[j - 1] = data_out;
            ctrl.burst_step_n = (j >= n - 1);
        end
    endtask
endmodule

//--- testbench/burst_sram_port_tb.sv
`timescale 1ns/10ps
`include "burst_sram_params.svh"
module burst_sram_port_tb
    import burst_sram_pkg::*;
;
    localparam logic [`WORD_W-1:0] MIX = 36'h123456789 | {9'h0, 9'h1FF, 9'h0, 9'h1FF};
    logic               clk = 0;
    logic               rst = 1;
    logic               seq = 1;
    logic               oe_n = 0;
    logic               sleep = 0;
    logic [`ADDR_W-1:0] addr;
    ctrl_t              ctrl;
    logic [`WORD_W-1:0] din, dout, oe;
    logic               pd;
    int                 errors = 0;
    int                 checked = 0;
    always #12.5 clk = ~clk;
    burst_sram_port burst_sram_port_i (.CLK_SYS(clk), .RST(rst), .SEQUENCE_SELECT(seq),
        .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(sleep), .ADDR(addr), .CTRL(ctrl),
        .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .POWER_DOWN(pd));
    host_model host_model_i (.clk_sys(clk), .data_out(dout), .addr(addr), .ctrl(ctrl),
        .data_in(din));
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Control word: ctl, proc, step, primary, secondary, high, gate, all, lanes a..d
    task automatic t_lanes();
        host_model_i.put(10'h010, 12'h66F, 36'h123456789);
        host_model_i.put(10'h010, 12'h65A, '1);
        host_model_i.put(10'h010, 12'h670, '0);
        host_model_i.put(10'h010, 12'hA40, '0);
        host_model_i.burst(1);
        check("lanes", host_model_i.q[0], MIX);
    endtask
    task automatic t_burst();
        for (int i = 0; i < 4; i++)
            host_model_i.put(10'h020 + 10'(i), 12'h66F, 36'(32 + i));
        for (int s = 0; s < 2; s++)
        begin
            seq = 1'(s);
            host_model_i.put(10'h022, 12'hA7F, '0);
            host_model_i.burst(4);
            for (int i = 0; i < 4; i++)
                check("burst", host_model_i.q[i], 36'(s ? 34 ^ i : 32 + (2 + i) % 4));
        end
    endtask
    task automatic t_select();
        logic [11:0] cw [6] = '{12'hA3F, 12'h67F, 12'hB7F, 12'h77F, 12'hAFF, 12'hA7F};
        logic [5:0]  want = 6'h19;
        for (int i = 0; i < 6; i++)
        begin
            host_model_i.put('0, cw[i], '0);
            check("power", {35'h0, pd}, {35'h0, want[i]});
        end
    endtask
    task automatic t_sleep();
        @(negedge clk);
        sleep = 1;
        #1;
        check("sleep", {35'h0, pd}, 36'h1);
        host_model_i.put(10'h010, 12'h66F, '0);
        sleep = 0;
        oe_n = 1;
        #1;
        check("oe", oe, '0);
        oe_n = 0;
        #1;
        check("oe", oe, '1);
        host_model_i.put(10'h010, 12'h67F, '0);
        host_model_i.burst(1);
        check("kept", host_model_i.q[0], MIX);
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        rst = 0;
        t_lanes();
        t_burst();
        t_select();
        t_sleep();
        wrap_up();
    end
    initial
    begin
        repeat (2000) @(posedge clk); // Run needs under 200 cycles
        errors++;
        wrap_up();
    end
endmodule
